// ---- logic/csc_cmd_unit.sv ----
// Operation
// - Command 0xB2 clears the step counter in every mode.
// - While a command runs, new command writes are dropped except soft reset.
// - A dropped command write sets the dropped-command error flag.
// - Accelerometer power commands occupy the register up to 3.8 ms.
// - Gyroscope commands 0x15 and 0x17 occupy the register up to 80 ms.
// - Magnetometer power commands occupy the register up to 0.5 ms.
// - All sensors suspended or low power adds 0.3 ms occupancy.
// - Soft reset adds 300 us system start-up time.
// - Command 0x03 starts fast offset calibration and stores offsets.
// - Pattern 0001_00nn sets the accelerometer power mode.
// - Pattern 0001_01nn sets the gyroscope power mode.
// - Pattern 0001_10nn sets the magnetometer interface power mode.
// - Command 0xA0 copies NVM-backed registers into NVM.
// - Command 0xB0 flushes FIFO data and keeps its configuration.
// - Command 0xB1 resets the interrupt engine, status and pin.
// - Command 0xB6 resets power modes, step configuration and step count; offsets and error flag keep their values.
// - Undefined command codes are ignored; while busy they still set the dropped-command error flag.
// - Command register is one 8-bit write-only location at 0x7E.
// - Step count reports steps since reset or last counter clear.
// - Calibration writes computed offsets into the offset registers.
`timescale 1ns/10ps
`include "csc_regs.svh"
module csc_cmd_unit #(
  parameter int GYR_TMAX_US = `CSC_GYR_TMAX_US,
  parameter int CNT_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic step_pulse_i,
  input wire logic [23:0] foc_result_i,
  output logic [1:0] acc_pmu_o,
  output logic [1:0] gyr_pmu_o,
  output logic [1:0] mag_pmu_o,
  output logic [15:0] step_conf_o,
  output logic foc_start_o,
  output logic nvm_prog_o,
  output logic fifo_flush_o,
  output logic int_reset_o,
  output logic soft_reset_o,
  output logic busy_o
);
  import csc_pkg::*;

  // The step counter and its read-back field are fixed at 16 bits.
  // The occupancy timer is 32 bits, so very long gyroscope times would overflow it.
  if (CNT_W != 16 || GYR_TMAX_US < 1 || GYR_TMAX_US > 40000000) begin : g_bad_param
    $error("csc_cmd_unit: unsupported parameter value");
  end

  localparam int CYC_ACC = `CSC_ACC_TMAX_US * `CSC_CLK_MHZ;
  localparam int CYC_GYR = GYR_TMAX_US * `CSC_CLK_MHZ;
  localparam int CYC_MAG = `CSC_MAG_TMAX_US * `CSC_CLK_MHZ;
  localparam int CYC_EXTRA = `CSC_EXTRA_US * `CSC_CLK_MHZ;
  localparam int CYC_START = `CSC_STARTUP_US * `CSC_CLK_MHZ;
  localparam int CYC_SHORT = `CSC_SHORT_US * `CSC_CLK_MHZ;

  // Power mode 00 is suspend, 10 is low power for every sensor here.
  function automatic logic quiet(input logic [1:0] m);
    quiet = (m == 2'h0) || (m == 2'h2);
  endfunction : quiet

  function automatic logic defined_cmd(input csc_cmd_t c);
    defined_cmd = (c == `CSC_CMD_FOC) || (c[7:4] == 4'h1 && c[3:2] != 2'h3)
      || (c == `CSC_CMD_PROG_NVM) || (c == `CSC_CMD_FIFO_FLUSH)
      || (c == `CSC_CMD_INT_RESET) || (c == `CSC_CMD_STEP_CLR)
      || (c == `CSC_CMD_SOFTRESET);
  endfunction : defined_cmd

  ////////////////////////////////////////////////////////////////////////////
  csc_state_t state;
  logic [31:0] timer;
  logic drop_err;
  logic [15:0] step_cnt;
  logic [23:0] offsets;
  logic soft_pend;
  logic bus_req;
  logic cmd_wr;
  csc_cmd_t cmd;
  logic accept;
  logic [31:0] next_time;
  logic [31:0] next_rdata;

  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign cmd_wr = bus_req && wb_we_i && wb_adr_i == `CSC_OFF_CMD && wb_sel_i[0];
  assign cmd = wb_dat_i[7:0];
  // Soft reset bypasses occupancy so a hung command can always be escaped.
  assign accept = cmd_wr && defined_cmd(cmd)
    && (state == CSC_IDLE || cmd == `CSC_CMD_SOFTRESET);

  always_comb begin
    next_time = 32'(CYC_SHORT);
    if (cmd[7:2] == 6'h04) begin
      next_time = 32'(CYC_ACC);
    end else if (cmd[7:2] == 6'h05) begin
      next_time = (cmd[1:0] == 2'h1 || cmd[1:0] == 2'h3) ? 32'(CYC_GYR) : 32'(CYC_SHORT);
    end else if (cmd[7:2] == 6'h06) begin
      next_time = 32'(CYC_MAG);
    end else if (cmd == `CSC_CMD_SOFTRESET) begin
      next_time = 32'(CYC_START);
    end
    if (quiet(acc_pmu_o) && quiet(gyr_pmu_o) && quiet(mag_pmu_o)) begin
      next_time = next_time + 32'(CYC_EXTRA);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= CSC_IDLE;
      timer <= 32'h0;
      busy_o <= 1'b0;
      soft_pend <= 1'b0;
    end else if (accept) begin
      state <= (cmd == `CSC_CMD_SOFTRESET) ? CSC_BOOT : CSC_BUSY;
      timer <= next_time;
      busy_o <= 1'b1;
      soft_pend <= (cmd == `CSC_CMD_SOFTRESET);
    end else begin
      case (state)
        CSC_IDLE: begin
          busy_o <= 1'b0;
        end
        CSC_BUSY, CSC_BOOT: begin
          if (timer <= 32'h1) begin
            state <= CSC_IDLE;
            busy_o <= 1'b0;
            soft_pend <= 1'b0;
          end else begin
            timer <= timer - 32'h1;
          end
        end
        default: begin
          state <= CSC_IDLE;
        end
      endcase
    end
  end

  // Command pulses are one cycle wide, issued at acceptance.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      foc_start_o <= 1'b0;
      nvm_prog_o <= 1'b0;
      fifo_flush_o <= 1'b0;
      int_reset_o <= 1'b0;
      soft_reset_o <= 1'b0;
    end else begin
      foc_start_o <= accept && cmd == `CSC_CMD_FOC;
      nvm_prog_o <= accept && cmd == `CSC_CMD_PROG_NVM;
      fifo_flush_o <= accept && cmd == `CSC_CMD_FIFO_FLUSH;
      int_reset_o <= accept && cmd == `CSC_CMD_INT_RESET;
      soft_reset_o <= accept && cmd == `CSC_CMD_SOFTRESET;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || (accept && cmd == `CSC_CMD_SOFTRESET)) begin
      acc_pmu_o <= 2'h0;
      gyr_pmu_o <= 2'h0;
      mag_pmu_o <= 2'h0;
    end else if (accept && cmd[7:4] == 4'h1) begin
      case (cmd[3:2])
        2'h0: acc_pmu_o <= cmd[1:0];
        2'h1: gyr_pmu_o <= cmd[1:0];
        2'h2: mag_pmu_o <= cmd[1:0];
        default: acc_pmu_o <= acc_pmu_o;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drop_err <= 1'b0;
    end else if (cmd_wr && !accept && state != CSC_IDLE) begin
      drop_err <= 1'b1;
    end else if (bus_req && wb_we_i && wb_adr_i == `CSC_OFF_STATUS && wb_dat_i[1]) begin
      drop_err <= 1'b0;
    end
  end

  // A clear wins over a step pulse in the same cycle; that step is not counted.
  always_ff @(posedge clk_i) begin
    if (rst_i || (accept && (cmd == `CSC_CMD_STEP_CLR || cmd == `CSC_CMD_SOFTRESET))) begin
      step_cnt <= 16'h0;
    end else if (step_pulse_i) begin
      step_cnt <= step_cnt + 16'h1;
    end
  end

  // Calibration results land one cycle after the start pulse.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      offsets <= 24'h0;
    end else if (foc_start_o) begin
      offsets <= foc_result_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || (accept && cmd == `CSC_CMD_SOFTRESET)) begin
      step_conf_o <= `CSC_STEP_CONF_RST;
    end else if (bus_req && wb_we_i && wb_adr_i == `CSC_OFF_STEP_CONF) begin
      if (wb_sel_i[0]) begin
        step_conf_o[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        step_conf_o[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_rdata = 32'h0;
    case (wb_adr_i)
      `CSC_OFF_STEP_CONF: next_rdata = {16'h0, step_conf_o};
      `CSC_OFF_STATUS: next_rdata = {29'h0, soft_pend, drop_err, busy_o};
      `CSC_OFF_STEP_CNT: next_rdata = {16'h0, step_cnt};
      `CSC_OFF_PMU: next_rdata = {26'h0, mag_pmu_o, gyr_pmu_o, acc_pmu_o};
      `CSC_OFF_OFFSET: next_rdata = {8'h0, offsets};
      default: next_rdata = 32'h0;
    endcase
  end

  // Command register reads as zero; it is write only.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= (bus_req && !wb_we_i) ? next_rdata : 32'h0;
    end
  end
endmodule : csc_cmd_unit

// ---- logic/csc_regs.svh ----
`ifndef CSC_REGS_SVH
`define CSC_REGS_SVH
`define CSC_OFF_STEP_CONF 8'h7a
`define CSC_OFF_CMD 8'h7e
`define CSC_OFF_STATUS 8'h80
`define CSC_OFF_STEP_CNT 8'h84
`define CSC_OFF_PMU 8'h88
`define CSC_OFF_OFFSET 8'h8c
`define CSC_STEP_CONF_RST 16'h0000
`define CSC_CMD_FOC 8'h03
`define CSC_CMD_PROG_NVM 8'ha0
`define CSC_CMD_FIFO_FLUSH 8'hb0
`define CSC_CMD_INT_RESET 8'hb1
`define CSC_CMD_STEP_CLR 8'hb2
`define CSC_CMD_SOFTRESET 8'hb6
`define CSC_ACC_TMAX_US 3800
`define CSC_GYR_TMAX_US 80000
`define CSC_MAG_TMAX_US 500
`define CSC_EXTRA_US 300
`define CSC_STARTUP_US 300
`define CSC_SHORT_US 100
`define CSC_CLK_MHZ 100
`endif

// ---- logic/csc_pkg.sv ----
package csc_pkg;
  typedef enum logic [2:0] {
    CSC_IDLE = 3'b001,
    CSC_BUSY = 3'b010,
    CSC_BOOT = 3'b100
  } csc_state_t;
  typedef logic [7:0] csc_cmd_t;
endpackage : csc_pkg

// ---- dv/csc_cmd_unit_properties.sv ----
`timescale 1ns/10ps
module csc_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic [1:0] acc_pmu_o,
  input wire logic [1:0] gyr_pmu_o,
  input wire logic [1:0] mag_pmu_o,
  input wire logic foc_start_o,
  input wire logic nvm_prog_o,
  input wire logic fifo_flush_o,
  input wire logic int_reset_o,
  input wire logic soft_reset_o,
  input wire logic busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic cw, ok, tk;
  logic [7:0] cd;
  logic [1:0] nn;
  logic [5:0] pm;
  logic [4:0] ep;
  assign cd = wb_dat_i[7:0];
  assign nn = wb_dat_i[1:0];
  assign pm = {mag_pmu_o, gyr_pmu_o, acc_pmu_o};
  assign cw = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 8'h7e && wb_sel_i[0];
  assign ok = cd inside {8'h03, [8'h10:8'h1b], 8'ha0, [8'hb0:8'hb2], 8'hb6};
  // Soft reset bypasses occupancy, so it counts as taken even while busy.
  assign tk = cw && (!busy_o || cd == 8'hb6);
  always_ff @(posedge clk_i) begin
    ep <= tk ? {cd == 8'hb6, cd == 8'hb1, cd == 8'hb0, cd == 8'ha0, cd == 8'h03} : 5'h0;
  end
  ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  pulse_map_a: assert property ({soft_reset_o, int_reset_o, fifo_flush_o, nvm_prog_o, foc_start_o} == ep)
    else $error("wrong command pulse");
  busy_hold_a: assert property (tk && ok |=> busy_o [*8])
    else $error("command not held");
  drop_keep_a: assert property (cw && busy_o && cd != 8'hb6 |=> $stable(pm))
    else $error("dropped command took effect");
  undef_quiet_a: assert property (cw && !busy_o && !ok |=> !busy_o && $stable(pm))
    else $error("undefined code had effect");
  acc_mode_a: assert property (tk && cd[7:2] == 6'h04 |=> acc_pmu_o == $past(nn))
    else $error("accel mode wrong");
  gyr_mode_a: assert property (tk && cd[7:2] == 6'h05 |=> gyr_pmu_o == $past(nn))
    else $error("gyro mode wrong");
  mag_mode_a: assert property (tk && cd[7:2] == 6'h06 |=> mag_pmu_o == $past(nn))
    else $error("mag mode wrong");
  cover property (cw && busy_o);
  cover property (tk && cd == 8'hb6 && busy_o);
  cover property ($fell(busy_o));
endmodule : csc_chk
bind csc_cmd_unit csc_chk chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_sel_i, .wb_dat_i, .wb_ack_o, .acc_pmu_o, .gyr_pmu_o, .mag_pmu_o, .foc_start_o,
  .nvm_prog_o, .fifo_flush_o, .int_reset_o, .soft_reset_o, .busy_o);

// ---- dv/csc_host.sv ----
`timescale 1ns/10ps
module csc_host (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o
);
  initial begin
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
  end
  // The request stands until ack is seen or 16 more cycles pass; with no ack by then the run ends as failed.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, 4'h3, d};
    @(posedge clk_i);
    while (ack_i !== 1'b1 && n < 16) begin
      @(posedge clk_i);
      n++;
    end
    if (ack_i !== 1'b1) begin
      testbench.err_count++;
      testbench.wrap_up();
    end
    q = dat_i;
    {cyc_o, stb_o} <= 2'b00;
  endtask : xfer
endmodule : csc_host

// ---- dv/testbench.sv ----
`timescale 1ns/10ps
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic step_pulse_i = 1'b0;
  logic cyc, stb, we, ack, busy;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] di, dq, q;
  logic [1:0] acc, gyr, mag;
  logic [15:0] conf;
  logic [4:0] pv;
  logic [15:0] cfg [3] = '{16'h0315, 16'h002d, 16'h071d};
  logic [7:0] code [4] = '{8'h03, 8'ha0, 8'hb0, 8'hb1};
  int err_count = 0;
  int tests_run = 0;
  int pc [5] = '{default: 0};
  csc_host host (.clk_i, .ack_i(ack), .dat_i(dq), .cyc_o(cyc), .stb_o(stb), .we_o(we),
    .adr_o(adr), .sel_o(sel), .dat_o(di));
  csc_cmd_unit #(.GYR_TMAX_US(10)) dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(di), .wb_dat_o(dq), .wb_ack_o(ack),
    .step_pulse_i, .foc_result_i(24'h0), .acc_pmu_o(acc), .gyr_pmu_o(gyr), .mag_pmu_o(mag),
    .step_conf_o(conf), .foc_start_o(pv[0]), .nvm_prog_o(pv[1]), .fifo_flush_o(pv[2]),
    .int_reset_o(pv[3]), .soft_reset_o(pv[4]), .busy_o(busy));
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    for (int k = 0; k < 5; k++) pc[k] <= pc[k] + pv[k];
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd
  // Occupancy is counted from the ack edge, hence the small window.
  task automatic idle(input int e);
    int n;
    n = 0;
    while (busy === 1'b1 && n < e + 9) begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0, n >= e - 2 && n <= e + 1}, 32'h1);
    if (busy !== 1'b0) wrap_up();
  endtask : idle
  task automatic steps(input int n);
    repeat (n) begin
      @(posedge clk_i);
      step_pulse_i <= 1'b1;
      @(posedge clk_i);
      step_pulse_i <= 1'b0;
    end
  endtask : steps
  task automatic wrap_up();
    if (err_count == 0 && tests_run > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(8'h7a, 32'h0);
    foreach (cfg[i]) begin
      wr(8'h7a, {16'h0, cfg[i]});
      rd(8'h7a, {16'h0, cfg[i]});
      chk({16'h0, conf}, {16'h0, cfg[i]});
    end
    rd(8'h40, 32'h0);
    rd(8'h7e, 32'h0);
  endtask : t_regs
  task automatic t_gyr();
    wr(8'h7e, 32'h15);
    chk({30'h0, gyr}, 32'h1);
    wr(8'h7e, 32'hb2);
    rd(8'h80, 32'h3);
    wr(8'h80, 32'h2);
    rd(8'h80, 32'h1);
    // Four transfers of three cycles each have already used part of the occupancy.
    idle(30988);
  endtask : t_gyr
  task automatic t_short();
    foreach (code[k]) begin
      wr(8'h7e, {24'h0, code[k]});
      idle(10000);
      chk(pc[k], 1);
    end
    wr(8'h7e, 32'h55);
    chk({31'h0, busy}, 32'h0);
  endtask : t_short
  task automatic t_soft();
    steps(3);
    rd(8'h84, 32'h3);
    wr(8'h7e, 32'h11);
    chk({30'h0, acc}, 32'h1);
    wr(8'h7e, 32'hb6);
    idle(30000);
    chk(pc[4], 1);
    rd(8'h88, 32'h0);
    rd(8'h7a, 32'h0);
    rd(8'h84, 32'h0);
    steps(2);
    rd(8'h84, 32'h2);
    wr(8'h7e, 32'hb2);
    rd(8'h84, 32'h0);
  endtask : t_soft
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_gyr();
    t_short();
    t_soft();
    wrap_up();
  end
endmodule : testbench
